// *** src/pfm_pin_mux.sv ***
// pin function multiplexer for port a bits 2..6 and port b bit 1
//
// Behaviour
// - timer2 ch4 on pa2 when unremapped, enabled, alt
// - pa2 feeds timer2 ch4 capture when unremapped
// - serial2 i2c clock open-drain on pa2
// - serial2 spi master clock out on pa2
// - pa2 is serial2 spi slave clock input
// - pa3 is serial2 spi slave select input
// - cpu trace clock on pa3 when enabled
// - timer2 ch2 out and capture on pa3
// - pa4 analog selects adc input 4
// - packet trace frame on pa4, trace off
// - cpu trace bit 2 on pa4, 4-wire
// - pa5 analog selects adc input 5
// - packet trace data on pa5, trace off
// - cpu trace bit 3 on pa5, 4-wire
// - pa5 low at reset requests bootloader
// - timer1 ch3 out and input on pa6
// - serial1 spi data out on pb1
// - serial1 i2c data or uart tx pb1
// - timer2 ch1 on pb1 when remapped
`include "pfm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pfm_pin_mux
(
   input  wire logic                         i_ref_clk,
   input  wire logic                         i_external_reset_n,
   // configuration
   input  wire logic [15:0]                  i_port_a_low_pin_config,
   input  wire logic [15:0]                  i_port_a_high_pin_config,
   input  wire logic [15:0]                  i_port_b_low_pin_config,
   input  wire logic [7:0]                   i_timer2_remap_option,
   input  wire logic [3:0]                   i_timer2_channel_output_enables,
   input  wire logic [3:0]                   i_timer1_channel_output_enables,
   input  wire pfm_pkg::pfm_serial_mode_type i_serial1_function_select,
   input  wire pfm_pkg::pfm_serial_mode_type i_serial2_function_select,
   input  wire logic [7:0]                   i_serial1_spi_setup,
   input  wire logic [7:0]                   i_serial2_spi_setup,
   input  wire logic                         i_trace_enable,
   input  wire logic                         i_trace_4wire,
   // function outputs from on-chip peripherals
   input  wire logic [5:0]                   i_gpio_out,
   input  wire logic                         i_timer2_channel1,
   input  wire logic                         i_timer2_channel2,
   input  wire logic                         i_timer2_channel4,
   input  wire logic                         i_timer1_channel3,
   input  wire logic                         i_serial2_i2c_clock,
   input  wire logic                         i_serial2_spi_clock,
   input  wire logic                         i_cpu_trace_clock,
   input  wire logic                         i_cpu_trace_bit2,
   input  wire logic                         i_cpu_trace_bit3,
   input  wire logic                         i_packet_trace_frame,
   input  wire logic                         i_packet_trace_serial_data,
   input  wire logic                         i_serial1_spi_master_out,
   input  wire logic                         i_serial1_spi_slave_out,
   input  wire logic                         i_serial1_i2c_data,
   input  wire logic                         i_serial1_uart_transmit,
   // pads
   input  wire logic [5:0]                   i_pin,
   output logic      [5:0]                   o_pin,
   output logic      [5:0]                   o_pin_oe_n,
   // function inputs to peripherals
   output logic      [5:0]                   o_gpio_in,
   output logic                              o_timer2_channel4,
   output logic                              o_timer2_channel2,
   output logic                              o_timer1_channel3,
   output logic                              o_serial2_spi_clock,
   output logic                              o_serial2_spi_select_n,
   output logic                              o_analog_input_4,
   output logic                              o_analog_input_5,
   output logic                              o_bootloader_request
);
   import pfm_pkg::*;

   // ***********************************************************
   // field decoding
   // ***********************************************************

   // true for either alternate output code
   function automatic logic is_alt(input logic [3:0] f);
   begin
      is_alt = (f == PFM_CFG_ALT) || (f == PFM_CFG_ALT_OD);
   end
   endfunction : is_alt

   // true for either plain output code
   function automatic logic is_gpo(input logic [3:0] f);
   begin
      is_gpo = (f == PFM_CFG_OUT) || (f == PFM_CFG_OUT_OD);
   end
   endfunction : is_gpo

   // true for the open-drain codes
   function automatic logic is_od(input logic [3:0] f);
   begin
      is_od = (f == PFM_CFG_OUT_OD) || (f == PFM_CFG_ALT_OD);
   end
   endfunction : is_od

   logic [3:0] cfg [5:0];

   // each pin's configuration field
   assign cfg[`PFM_PA2] = i_port_a_low_pin_config[`PFM_PA2_POS +: 4];
   assign cfg[`PFM_PA3] = i_port_a_low_pin_config[`PFM_PA3_POS +: 4];
   assign cfg[`PFM_PA4] = i_port_a_high_pin_config[`PFM_PA4_POS +: 4];
   assign cfg[`PFM_PA5] = i_port_a_high_pin_config[`PFM_PA5_POS +: 4];
   assign cfg[`PFM_PA6] = i_port_a_high_pin_config[`PFM_PA6_POS +: 4];
   assign cfg[`PFM_PB1] = i_port_b_low_pin_config[`PFM_PB1_POS +: 4];

   // ***********************************************************
   // pad input synchroniser
   // ***********************************************************

   logic [5:0] pin_meta_q;
   logic [5:0] pin_sync_q;

   // pads are asynchronous to the core clock; idle high
   always_ff @(posedge i_ref_clk or negedge i_external_reset_n)
   begin
      if (!i_external_reset_n)
      begin
         pin_meta_q <= `PFM_PAD_RST;
         pin_sync_q <= `PFM_PAD_RST;
      end
      else
      begin
         pin_meta_q <= i_pin;
         pin_sync_q <= pin_meta_q;
      end
   end

   // ***********************************************************
   // output selection
   // ***********************************************************

   logic       t2c4_on;
   logic       t2c2_on;
   logic       t2c1_on;
   logic       ser2_spi;
   logic       ser2_mst;
   logic       ser1_spi;
   logic       ser1_mst;
   logic       alt_en  [5:0];
   logic       alt_val [5:0];

   // timer channel claims (remap bit decides the pad)
   assign t2c4_on = !i_timer2_remap_option[`PFM_RMP_CH4] &&
                    i_timer2_channel_output_enables[`PFM_T2_CH4_OE];
   assign t2c2_on = !i_timer2_remap_option[`PFM_RMP_CH2] &&
                    i_timer2_channel_output_enables[`PFM_T2_CH2_OE];
   assign t2c1_on = i_timer2_remap_option[`PFM_RMP_CH1] &&
                    i_timer2_channel_output_enables[`PFM_T2_CH1_OE];
   assign ser2_spi = i_serial2_function_select == PFM_SER_SPI;
   assign ser2_mst = i_serial2_spi_setup[`PFM_SPI_MASTER];
   assign ser1_spi = i_serial1_function_select == PFM_SER_SPI;
   assign ser1_mst = i_serial1_spi_setup[`PFM_SPI_MASTER];

   // pa2: timer first, then serial2 i2c or spi master clock
   always_comb
   begin
      alt_en[`PFM_PA2]  = 1'b0;
      alt_val[`PFM_PA2] = 1'b1;
      if (t2c4_on)
      begin
         alt_en[`PFM_PA2]  = 1'b1;
         alt_val[`PFM_PA2] = i_timer2_channel4;
      end
      else if (i_serial2_function_select == PFM_SER_I2C)
      begin
         alt_en[`PFM_PA2]  = 1'b1;
         alt_val[`PFM_PA2] = i_serial2_i2c_clock;
      end
      else if (ser2_spi && ser2_mst)
      begin
         alt_en[`PFM_PA2]  = 1'b1;
         alt_val[`PFM_PA2] = i_serial2_spi_clock;
      end
   end

   // pa3: timer first, then the trace clock
   always_comb
   begin
      alt_en[`PFM_PA3]  = 1'b0;
      alt_val[`PFM_PA3] = 1'b1;
      if (t2c2_on)
      begin
         alt_en[`PFM_PA3]  = 1'b1;
         alt_val[`PFM_PA3] = i_timer2_channel2;
      end
      else if (i_trace_enable)
      begin
         alt_en[`PFM_PA3]  = 1'b1;
         alt_val[`PFM_PA3] = i_cpu_trace_clock;
      end
   end

   // pa4/pa5: packet trace when cpu trace is off, else 4-wire data in 4-wire mode only
   always_comb
   begin
      alt_en[`PFM_PA4]  = 1'b0;
      alt_val[`PFM_PA4] = 1'b1;
      alt_en[`PFM_PA5]  = 1'b0;
      alt_val[`PFM_PA5] = 1'b1;
      if (!i_trace_enable)
      begin
         alt_en[`PFM_PA4]  = 1'b1;
         alt_val[`PFM_PA4] = i_packet_trace_frame;
         alt_en[`PFM_PA5]  = 1'b1;
         alt_val[`PFM_PA5] = i_packet_trace_serial_data;
      end
      else if (i_trace_4wire)
      begin
         alt_en[`PFM_PA4]  = 1'b1;
         alt_val[`PFM_PA4] = i_cpu_trace_bit2;
         alt_en[`PFM_PA5]  = 1'b1;
         alt_val[`PFM_PA5] = i_cpu_trace_bit3;
      end
   end

   // pa6: timer 1 channel 3 only; procedural like the other slots so
   // the arrays keep a single kind of driver
   always_comb
   begin
      alt_en[`PFM_PA6]  =
         i_timer1_channel_output_enables[`PFM_T1_CH3_OE];
      alt_val[`PFM_PA6] = i_timer1_channel3;
   end

   // pb1: remapped timer first, then serial1 per mode
   always_comb
   begin
      alt_en[`PFM_PB1]  = 1'b0;
      alt_val[`PFM_PB1] = 1'b1;
      if (t2c1_on)
      begin
         alt_en[`PFM_PB1]  = 1'b1;
         alt_val[`PFM_PB1] = i_timer2_channel1;
      end
      else if (ser1_spi)
      begin
         alt_en[`PFM_PB1]  = 1'b1;
         alt_val[`PFM_PB1] = ser1_mst ? i_serial1_spi_master_out
                                      : i_serial1_spi_slave_out;
      end
      else if (i_serial1_function_select == PFM_SER_I2C)
      begin
         alt_en[`PFM_PB1]  = 1'b1;
         alt_val[`PFM_PB1] = i_serial1_i2c_data;
      end
      else if (i_serial1_function_select == PFM_SER_UART)
      begin
         alt_en[`PFM_PB1]  = 1'b1;
         alt_val[`PFM_PB1] = i_serial1_uart_transmit;
      end
   end

   // ***********************************************************
   // pad drivers
   // ***********************************************************

   genvar g;
   generate
      for (g = 0; g < `PFM_NPINS; g = g + 1)
      begin : g_pad
         logic drv;
         logic val;
         // alternate code hands the pad to the function, else gpio
         always_comb
         begin
            drv = 1'b0;
            val = 1'b1;
            if (is_alt(cfg[g]))
            begin
               drv = alt_en[g];
               val = alt_val[g];
            end
            else if (is_gpo(cfg[g]))
            begin
               drv = 1'b1;
               val = i_gpio_out[g];
            end
         end
         // open drain only pulls low; analog codes never drive
         always_ff @(posedge i_ref_clk or negedge i_external_reset_n)
         begin
            if (!i_external_reset_n)
            begin
               o_pin[g]      <= 1'b1;
               o_pin_oe_n[g] <= 1'b1;
            end
            else
            begin
               o_pin[g]      <= val;
               o_pin_oe_n[g] <= !(drv && !(is_od(cfg[g]) && val));
            end
         end
      end
   endgenerate

   // ***********************************************************
   // function inputs
   // ***********************************************************

   // analog pa4/pa5 read zero so no digital logic toggles on them
   always_ff @(posedge i_ref_clk or negedge i_external_reset_n)
   begin
      if (!i_external_reset_n)
      begin
         o_gpio_in        <= 6'h0;
         o_analog_input_4 <= 1'b0;
         o_analog_input_5 <= 1'b0;
      end
      else
      begin
         o_gpio_in <= pin_sync_q;
         o_gpio_in[`PFM_PA4] <= (cfg[`PFM_PA4] != PFM_CFG_ANALOG) &&
                                pin_sync_q[`PFM_PA4];
         o_gpio_in[`PFM_PA5] <= (cfg[`PFM_PA5] != PFM_CFG_ANALOG) &&
                                pin_sync_q[`PFM_PA5];
         o_analog_input_4 <= cfg[`PFM_PA4] == PFM_CFG_ANALOG;
         o_analog_input_5 <= cfg[`PFM_PA5] == PFM_CFG_ANALOG;
      end
   end

   // capture inputs follow the remap; read low when remapped away
   always_ff @(posedge i_ref_clk or negedge i_external_reset_n)
   begin
      if (!i_external_reset_n)
      begin
         o_timer2_channel4 <= 1'b0;
         o_timer2_channel2 <= 1'b0;
         o_timer1_channel3 <= 1'b0;
      end
      else
      begin
         o_timer2_channel4 <= !i_timer2_remap_option[`PFM_RMP_CH4] &&
                              pin_sync_q[`PFM_PA2];
         o_timer2_channel2 <= !i_timer2_remap_option[`PFM_RMP_CH2] &&
                              pin_sync_q[`PFM_PA3];
         o_timer1_channel3 <= pin_sync_q[`PFM_PA6];
      end
   end

   // spi slave inputs only in slave role; select idles inactive
   always_ff @(posedge i_ref_clk or negedge i_external_reset_n)
   begin
      if (!i_external_reset_n)
      begin
         o_serial2_spi_clock    <= 1'b0;
         o_serial2_spi_select_n <= 1'b1;
      end
      else
      begin
         o_serial2_spi_clock <= ser2_spi && !ser2_mst &&
                                pin_sync_q[`PFM_PA2];
         o_serial2_spi_select_n <= !(ser2_spi && !ser2_mst) ||
                                   pin_sync_q[`PFM_PA3];
      end
   end

   // ***********************************************************
   // bootloader strap
   // ***********************************************************

   pfm_boot_state_type boot_q;
   logic [1:0]         boot_cnt_q;

   // wait until the synchroniser holds real pad data, then latch
   always_ff @(posedge i_ref_clk or negedge i_external_reset_n)
   begin
      if (!i_external_reset_n)
      begin
         boot_q     <= PFM_BOOT_WAIT;
         boot_cnt_q <= 2'h0;
      end
      else
      begin
         case (boot_q)
            PFM_BOOT_WAIT:
            begin
               boot_cnt_q <= boot_cnt_q + 2'h1;
               if (boot_cnt_q == `PFM_BOOT_SETTLE - 2'h1)
                  boot_q <= PFM_BOOT_TAKE;
            end
            PFM_BOOT_TAKE:
               boot_q <= PFM_BOOT_DONE;
            PFM_BOOT_DONE:
               boot_q <= PFM_BOOT_DONE;
            default:
               boot_q <= PFM_BOOT_WAIT;
         endcase
      end
   end

   // one sample only; later pad activity on pa5 is ignored
   always_ff @(posedge i_ref_clk or negedge i_external_reset_n)
   begin
      if (!i_external_reset_n)
         o_bootloader_request <= 1'b0;
      else if (boot_q == PFM_BOOT_TAKE)
         o_bootloader_request <= !pin_sync_q[`PFM_PA5];
   end

endmodule : pfm_pin_mux
`default_nettype wire

// *** src/pfm_pkg.sv ***
// pin function mux types
package pfm_pkg;
   // serial controller function select
   typedef enum logic [1:0] {
      PFM_SER_OFF  = 2'h0,
      PFM_SER_UART = 2'h1,
      PFM_SER_SPI  = 2'h2,
      PFM_SER_I2C  = 2'h3
   } pfm_serial_mode_type;
   // per-pin configuration field codes
   typedef enum logic [3:0] {
      PFM_CFG_ANALOG = 4'h0,
      PFM_CFG_OUT    = 4'h1,
      PFM_CFG_IN     = 4'h4,
      PFM_CFG_OUT_OD = 4'h5,
      PFM_CFG_IN_PUD = 4'h8,
      PFM_CFG_ALT    = 4'h9,
      PFM_CFG_ALT_OD = 4'hD
   } pfm_pin_cfg_type;
   // bootloader strap sampler, one-hot
   typedef enum logic [2:0] {
      PFM_BOOT_WAIT  = 3'b001,
      PFM_BOOT_TAKE  = 3'b010,
      PFM_BOOT_DONE  = 3'b100
   } pfm_boot_state_type;
endpackage : pfm_pkg

// *** src/pfm_regs.svh ***
// pin function mux constants: field positions, encodings, timing
`ifndef PFM_REGS_SVH
`define PFM_REGS_SVH
// pin slots inside the pad vectors
`define PFM_PA2 0
`define PFM_PA3 1
`define PFM_PA4 2
`define PFM_PA5 3
`define PFM_PA6 4
`define PFM_PB1 5
`define PFM_NPINS 6
// low bit of each pin's 4-bit configuration field
`define PFM_PA2_POS 8
`define PFM_PA3_POS 12
`define PFM_PA4_POS 0
`define PFM_PA5_POS 4
`define PFM_PA6_POS 8
`define PFM_PB1_POS 4
// timer remap option bits
`define PFM_RMP_CH1 4
`define PFM_RMP_CH2 5
`define PFM_RMP_CH4 7
// channel output enable bits
`define PFM_T2_CH1_OE 0
`define PFM_T2_CH2_OE 1
`define PFM_T2_CH4_OE 3
`define PFM_T1_CH3_OE 2
// spi setup: master role bit
`define PFM_SPI_MASTER 4
// reset values of the pad state
`define PFM_PAD_RST 6'h3F
// settle cycles for the strap sampler after reset release
`define PFM_BOOT_SETTLE 2'h2
`endif

// *** tb/pfm_periph_model.sv ***
// peripheral side model: timer, serial and trace function sources
`timescale 1ns/1ps
`default_nettype none

module pfm_periph_model
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_external_reset_n,
   input  wire logic [14:0] i_level,
   output logic      [14:0] o_func
);
   // sources launch from the system clock, so requested levels show a
   // cycle late; idle sources sit low while the chip is in reset
   always_ff @(posedge i_ref_clk or negedge i_external_reset_n)
   begin
      if (!i_external_reset_n)
      begin
         o_func <= 15'h0000;
      end
      else
      begin
         o_func <= i_level;
      end
   end
endmodule : pfm_periph_model

`default_nettype wire

// *** tb/pfm_pin_mux_monitor.sv ***
// concurrent checks on the pin function mux ports
`timescale 1ns/1ps
`default_nettype none

module pfm_pin_mux_monitor
(
   input wire logic        i_ref_clk,
   input wire logic        i_external_reset_n,
   input wire logic [15:0] i_port_a_low_pin_config,
   input wire logic [15:0] i_port_a_high_pin_config,
   input wire logic [7:0]  i_timer2_remap_option,
   input wire logic [3:0]  i_timer2_channel_output_enables,
   input wire pfm_pkg::pfm_serial_mode_type i_serial2_function_select,
   input wire logic [7:0]  i_serial2_spi_setup,
   input wire logic        i_trace_enable,
   input wire logic        i_timer2_channel4,
   input wire logic        i_timer2_channel2,
   input wire logic        i_serial2_i2c_clock,
   input wire logic        i_serial2_spi_clock,
   input wire logic        i_cpu_trace_clock,
   input wire logic        i_packet_trace_frame,
   input wire logic [5:0]  o_pin,
   input wire logic [5:0]  o_pin_oe_n,
   input wire logic        o_timer2_channel4,
   input wire logic        o_analog_input_4
);
   import pfm_pkg::*;
   // pad fields and timer ownership of pa2 and pa3
   wire logic [3:0] f_pa2 = i_port_a_low_pin_config[11:8];
   wire logic [3:0] f_pa3 = i_port_a_low_pin_config[15:12];
   wire logic [3:0] f_pa4 = i_port_a_high_pin_config[3:0];
   wire logic       t4_on = i_timer2_channel_output_enables[3]
                            && !i_timer2_remap_option[7];
   wire logic       t2_on = i_timer2_channel_output_enables[1]
                            && !i_timer2_remap_option[5];

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_external_reset_n);

   // pads are registered: each answer lands one cycle after its cause
   property p_pa2_tim;
      f_pa2 == PFM_CFG_ALT && t4_on
      |=> o_pin[0] == $past(i_timer2_channel4) && !o_pin_oe_n[0];
   endproperty
   a_pa2_tim: assert property (p_pa2_tim)
      else $error("pa2 timer drive wrong");
   property p_ch4_away;
      i_timer2_remap_option[7] |=> !o_timer2_channel4;
   endproperty
   a_ch4_away: assert property (p_ch4_away)
      else $error("ch4 capture not cut off");
   property p_pa2_scl;
      f_pa2 == PFM_CFG_ALT_OD && i_serial2_function_select == PFM_SER_I2C
      && !t4_on && !i_serial2_i2c_clock |=> !o_pin_oe_n[0] && !o_pin[0];
   endproperty
   a_pa2_scl: assert property (p_pa2_scl)
      else $error("pa2 i2c low not driven");
   property p_pa2_sck;
      f_pa2 == PFM_CFG_ALT && i_serial2_function_select == PFM_SER_SPI
      && i_serial2_spi_setup[4] && !t4_on
      |-> ##1 o_pin[0] == $past(i_serial2_spi_clock) && !o_pin_oe_n[0];
   endproperty
   a_pa2_sck: assert property (p_pa2_sck)
      else $error("pa2 spi clock drive wrong");
   property p_pa3_clk;
      f_pa3 == PFM_CFG_ALT && i_trace_enable && !t2_on
      |=> o_pin[1] == $past(i_cpu_trace_clock);
   endproperty
   a_pa3_clk: assert property (p_pa3_clk)
      else $error("pa3 trace clock wrong");
   property p_pa3_tim;
      f_pa3 == PFM_CFG_ALT && t2_on
      |=> o_pin[1] == $past(i_timer2_channel2) && !o_pin_oe_n[1];
   endproperty
   a_pa3_tim: assert property (p_pa3_tim)
      else $error("pa3 timer drive wrong");
   property p_pa4_an;
      f_pa4 == PFM_CFG_ANALOG [*2] |-> o_analog_input_4 && o_pin_oe_n[2];
   endproperty
   a_pa4_an: assert property (p_pa4_an)
      else $error("pa4 not handed to analog");
   property p_pa4_ptf;
      f_pa4 == PFM_CFG_ALT && !i_trace_enable
      |=> o_pin[2] == $past(i_packet_trace_frame) && !o_pin_oe_n[2];
   endproperty
   a_pa4_ptf: assert property (p_pa4_ptf)
      else $error("pa4 packet frame wrong");
endmodule : pfm_pin_mux_monitor

bind pfm_pin_mux pfm_pin_mux_monitor pfm_pin_mux_monitor_i (.*);

`default_nettype wire

// *** tb/tb_pfm_pin_mux.sv ***
// self-checking bench for the pin function mux
`timescale 1ns/1ps
`default_nettype none

module tb_pfm_pin_mux;
   import pfm_pkg::*;
   logic                i_ref_clk = 1'b0;
   logic                i_external_reset_n = 1'b0;
   logic [15:0]         i_port_a_low_pin_config, i_port_a_high_pin_config;
   logic [15:0]         i_port_b_low_pin_config;
   logic [7:0]          i_timer2_remap_option;
   logic [3:0]          i_timer2_channel_output_enables;
   logic [3:0]          i_timer1_channel_output_enables;
   pfm_serial_mode_type i_serial1_function_select, i_serial2_function_select;
   logic [7:0]          i_serial1_spi_setup, i_serial2_spi_setup;
   logic                i_trace_enable, i_trace_4wire;
   logic [5:0]          i_gpio_out, i_pin, o_pin, o_pin_oe_n, o_gpio_in;
   logic                o_timer2_channel4, o_timer2_channel2, o_timer1_channel3;
   logic                o_serial2_spi_clock, o_serial2_spi_select_n;
   logic                o_analog_input_4, o_analog_input_5;
   logic                o_bootloader_request;
   logic [14:0]         fv;
   wire logic [14:0]    f;
   int                  errors = 0;
   int                  n_checks = 0;

   // 50 MHz system clock
   always #10 i_ref_clk = ~i_ref_clk;

   pfm_periph_model pfm_periph_model_i
      (.i_ref_clk, .i_external_reset_n, .i_level(fv), .o_func(f));
   pfm_pin_mux pfm_pin_mux_i
   (
      .*,
      .i_timer2_channel1(f[0]),   .i_timer2_channel2(f[1]),
      .i_timer2_channel4(f[2]),   .i_timer1_channel3(f[3]),
      .i_serial2_i2c_clock(f[4]), .i_serial2_spi_clock(f[5]),
      .i_cpu_trace_clock(f[6]),   .i_cpu_trace_bit2(f[7]),
      .i_cpu_trace_bit3(f[8]),    .i_packet_trace_frame(f[9]),
      .i_packet_trace_serial_data(f[10]),
      .i_serial1_spi_master_out(f[11]), .i_serial1_spi_slave_out(f[12]),
      .i_serial1_i2c_data(f[13]), .i_serial1_uart_transmit(f[14])
   );

   // inputs always move 1 ns after the edge, so sampling never races
   task step(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask : step

   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // pin fields as given, every other control back to off
   task set_cfg(input logic [15:0] al, input logic [15:0] ah,
                input logic [15:0] bl);
      i_port_a_low_pin_config = al;
      i_port_a_high_pin_config = ah;
      i_port_b_low_pin_config = bl;
      i_timer2_remap_option = 8'h00;
      i_timer2_channel_output_enables = 4'h0;
      i_timer1_channel_output_enables = 4'h0;
      i_serial1_function_select = PFM_SER_OFF;
      i_serial2_function_select = PFM_SER_OFF;
      i_serial1_spi_setup = 8'h00;
      i_serial2_spi_setup = 8'h00;
      i_trace_enable = 1'b0;
      i_trace_4wire = 1'b0;
      i_gpio_out = 6'h00;
      fv = 15'h0000;
   endtask : set_cfg

   // source k alone at each level, all others opposite, so only the
   // right source can match; open drain releases the pad on a one
   task fn(input string nm, input int s, input int k, input bit od);
      for (int v = 0; v < 2; v++)
      begin
         fv = v ? 15'h0001 << k : ~(15'h0001 << k);
         step(2);
         chk(nm, {7'h00, o_pin_oe_n[s]}, 8'(od & v));
         if (!(od && v)) chk(nm, {7'h00, o_pin[s]}, 8'(v));
      end
   endtask : fn

   task stop_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   // main sequence
   initial
   begin
      set_cfg(16'h4444, 16'h4444, 16'h4444);
      i_pin = 6'h37;
      step(9);
      chk("rst_oe", {2'b00, o_pin_oe_n}, 8'h3F);
      step(1);
      i_external_reset_n = 1'b1;
      step(6);
      chk("boot_req", {7'h00, o_bootloader_request}, 8'h01);
      i_external_reset_n = 1'b0;
      i_pin = 6'h3F;
      step(2);
      i_external_reset_n = 1'b1;
      step(6);
      chk("boot_none", {7'h00, o_bootloader_request}, 8'h00);
      set_cfg(16'h1100, 16'h0111, 16'h0010);
      i_gpio_out = 6'h2D;
      step(2);
      chk("gpio_out", {2'b00, o_pin}, 8'h2D);
      chk("gpio_oe", {2'b00, o_pin_oe_n}, 8'h00);
      set_cfg(16'h4444, 16'h4444, 16'h4444);
      i_pin = 6'h16;
      step(4);
      chk("gpio_in", {2'b00, o_gpio_in}, 8'h16);
      set_cfg(16'h0900, 16'h4444, 16'h4444);
      i_timer2_channel_output_enables = 4'h8;
      i_serial2_function_select = PFM_SER_SPI;
      i_serial2_spi_setup = 8'h10;
      fn("pa2_tim", 0, 2, 0);
      i_timer2_remap_option = 8'h80;
      fn("pa2_sck", 0, 5, 0);
      i_serial2_function_select = PFM_SER_I2C;
      i_port_a_low_pin_config = 16'h0D00;
      fn("pa2_scl", 0, 4, 1);
      set_cfg(16'h4444, 16'h4444, 16'h4444);
      i_serial2_function_select = PFM_SER_SPI;
      i_pin = 6'h01;
      step(4);
      chk("pa23_in", {4'h0, o_timer2_channel4, o_timer2_channel2,
          o_serial2_spi_clock, o_serial2_spi_select_n}, 8'h0A);
      i_pin = 6'h02;
      step(4);
      chk("pa23_in", {4'h0, o_timer2_channel4, o_timer2_channel2,
          o_serial2_spi_clock, o_serial2_spi_select_n}, 8'h05);
      i_timer2_remap_option = 8'hA0;
      i_pin = 6'h03;
      step(4);
      chk("pa23_rmp", {4'h0, o_timer2_channel4, o_timer2_channel2,
          o_serial2_spi_clock, o_serial2_spi_select_n}, 8'h03);
      set_cfg(16'h9000, 16'h4444, 16'h4444);
      i_timer2_channel_output_enables = 4'h2;
      i_trace_enable = 1'b1;
      fn("pa3_tim", 1, 1, 0);
      i_timer2_remap_option = 8'h20;
      fn("pa3_clk", 1, 6, 0);
      set_cfg(16'h4444, 16'h4400, 16'h4444);
      step(2);
      chk("analog", {4'h0, o_analog_input_4, o_analog_input_5,
          o_pin_oe_n[3:2]}, 8'h0F);
      i_port_a_high_pin_config = 16'h4499;
      fn("pa4_ptf", 2, 9, 0);
      fn("pa5_ptd", 3, 10, 0);
      i_trace_enable = 1'b1;
      i_trace_4wire = 1'b1;
      fn("pa4_tb2", 2, 7, 0);
      fn("pa5_tb3", 3, 8, 0);
      i_trace_4wire = 1'b0;
      step(2);
      chk("pa45_off", {6'h00, o_pin_oe_n[3:2]}, 8'h03);
      set_cfg(16'h4444, 16'h4944, 16'h4444);
      step(2);
      chk("pa6_off", {7'h00, o_pin_oe_n[4]}, 8'h01);
      i_timer1_channel_output_enables = 4'h4;
      fn("pa6_tim", 4, 3, 0);
      i_pin = 6'h10;
      step(4);
      chk("pa6_in", {7'h00, o_timer1_channel3}, 8'h01);
      set_cfg(16'h4444, 16'h4444, 16'h4494);
      i_serial1_function_select = PFM_SER_SPI;
      i_serial1_spi_setup = 8'h10;
      fn("pb1_mo", 5, 11, 0);
      i_serial1_spi_setup = 8'h00;
      fn("pb1_so", 5, 12, 0);
      i_serial1_function_select = PFM_SER_UART;
      i_timer2_channel_output_enables = 4'h1;
      fn("pb1_tx", 5, 14, 0);
      i_timer2_remap_option = 8'h10;
      fn("pb1_tim", 5, 0, 0);
      i_timer2_remap_option = 8'h00;
      i_serial1_function_select = PFM_SER_I2C;
      i_port_b_low_pin_config = 16'h44D4;
      fn("pb1_sda", 5, 13, 1);
      stop_test();
   end
endmodule : tb_pfm_pin_mux

`default_nettype wire
